//--- hdl/hcib_bank.sv
`timescale 1ns/1ps
`default_nettype none
module hcib_bank
  import hcib_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic ext_trigger,
  input wire logic [15:0] pa_current_meas,
  input wire logic [1:0] stage_rx_gain_atten,
  input wire logic stage_switch_pos,
  output logic spi_miso,
  output logic [1:0] reference_source_select,
  output logic [1:0] reference_output_enable,
  output logic [1:0] local_osc_source_select_rx,
  output logic [1:0] local_osc_source_select_tx,
  output logic duplex_path_select,
  output logic tdd_direction_select,
  output logic [1:0] trigger_group_enable,
  output logic [2:0] if_filter_rx,
  output logic [2:0] if_filter_tx,
  output logic [2:0] rx_baseband_filter_select,
  output logic [2:0] tx_external_filter_select,
  output logic [3:0] antenna_output_lines,
  output logic [15:0] cv_gain_rx,
  output logic [15:0] cv_gain_tx,
  output logic [15:0] rx_gain_voltage_one,
  output logic [15:0] rx_gain_voltage_two,
  output logic amp_bias_loop_enable,
  output logic [15:0] amp_bias_current_target,
  output logic active_path_r,
  output logic duplex_switch_position,
  output logic gain_apply_pulse,
  output logic system_restart_pulse
);
  logic sclk_s, cs_n_s, mosi_s, trig_s;
  logic sclk_d_r, trig_d_r;
  logic [4:0] bit_cnt_r;
  logic [31:0] rx_shift_r;
  logic [31:0] tx_shift_r;
  logic [31:0] resp_r;
  logic frame_done;
  logic sclk_rise, sclk_fall, trig_rise;
  logic [31:0] word;
  logic is_read;
  logic [6:0] cmd;
  logic [7:0] cid;
  logic [15:0] val;
  logic id_ok, wr_ok, ref_clash;
  logic [15:0] rd_val;
  logic cmd_err;
  logic soft_rst;

  // synchronise the serial and trigger pins before use
  hcib_sync u_sync_sclk (.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(spi_sclk), .pin_out(sclk_s));
  hcib_sync u_sync_cs (.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(spi_cs_n), .pin_out(cs_n_s));
  hcib_sync u_sync_mosi (.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(spi_mosi), .pin_out(mosi_s));
  hcib_sync u_sync_trig (.sys_clk(sys_clk), .rst_n(rst_n), .pin_in(ext_trigger), .pin_out(trig_s));

  // edge detection on synchronised copies
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      trig_d_r <= trig_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_n_s;
  assign trig_rise = trig_s & ~trig_d_r;

  // msb-first receive shifter, frame ends on 32nd rising edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 5'h00;
      rx_shift_r <= 32'h00000000;
    end else if (cs_n_s) begin
      bit_cnt_r <= 5'h00;
    end else if (sclk_rise) begin
      rx_shift_r <= {rx_shift_r[30:0], mosi_s};
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end
  assign frame_done = sclk_rise && (bit_cnt_r == 5'h1F);
  assign word = {rx_shift_r[30:0], mosi_s};

  // command decode
  assign is_read = word[FRAME_BITS-1-(7-OP_BIT)];
  assign cmd = word[30:24];
  assign cid = word[ID_HI:ID_LO];
  assign val = word[15:0];
  assign ref_clash = (cid == ID_REFERENCE_SOURCE_SELECT && val == REF_EXTERNAL && reference_output_enable != 2'h0)
                  || (cid == ID_REF_OUT && val != REF_OUT_OFF
                      && reference_source_select == REF_EXTERNAL[1:0]);

  // control id legality and read values
  always_comb begin
    id_ok = 1'b1;
    wr_ok = 1'b1;
    rd_val = 16'h0000;
    unique case (cid)
      ID_REFERENCE_SOURCE_SELECT: begin
        rd_val = {14'h0000, reference_source_select};
        wr_ok = (val <= REFERENCE_SOURCE_SELECT_MAX);
      end
      ID_REF_OUT: begin
        rd_val = {14'h0000, reference_output_enable};
        wr_ok = (val <= REF_OUT_MAX);
      end
      ID_LOCAL_OSC_SOURCE_SELECT: begin
        rd_val = {14'h0000, active_path_r ? local_osc_source_select_tx : local_osc_source_select_rx};
        wr_ok = (val <= LOCAL_OSC_SOURCE_SELECT_MAX);
      end
      ID_DUPLEX: rd_val = {15'h0000, duplex_path_select};
      ID_TDD_DIR: rd_val = {15'h0000, tdd_direction_select};
      ID_TRIG: rd_val = {14'h0000, trigger_group_enable};
      ID_IF_FLT: rd_val = {13'h0000, active_path_r ? if_filter_tx : if_filter_rx};
      ID_RXBB_FLT: rd_val = {13'h0000, rx_baseband_filter_select};
      ID_TXBB_FLT: rd_val = {13'h0000, tx_external_filter_select};
      ID_ANT: rd_val = {12'h000, antenna_output_lines};
      ID_CV_GAIN: rd_val = active_path_r ? cv_gain_tx : cv_gain_rx;
      ID_RX_GAIN1: rd_val = rx_gain_voltage_one;
      ID_RX_GAIN2: rd_val = rx_gain_voltage_two;
      ID_AMP_BIAS_LOOP_ENABLE: rd_val = 16'h0000;
      ID_PA_CUR: rd_val = 16'h0000;
      ID_SYS_RST: begin
        rd_val = 16'h0000;
        wr_ok = (val == RESET_KEY);
      end
      default: id_ok = 1'b0;
    endcase
  end

  // error status for the next response byte
  always_comb begin
    cmd_err = 1'b0;
    if (cmd == CMD_CTRL)
      cmd_err = !id_ok || (!is_read && (!wr_ok || ref_clash));
    else if (cmd == CMD_STAT)
      cmd_err = !(cid >= SID_CHAN && cid <= SID_PA_CUR) || !is_read;
    else if (cmd != CMD_NULL && cmd != CMD_PATH)
      cmd_err = 1'b1;
  end

  assign soft_rst = frame_done && !is_read && cmd == CMD_CTRL && cid == ID_SYS_RST && val == RESET_KEY;

  // response word, loaded on frame end and sent next frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_r <= 32'h00000000;
    end else if (frame_done) begin
      resp_r[31] <= cmd_err;
      resp_r[30:24] <= cmd;
      resp_r[23:16] <= cid;
      if (is_read && cmd == CMD_CTRL && id_ok)
        resp_r[15:0] <= rd_val;
      else if (is_read && cmd == CMD_STAT)
        unique case (cid)
          SID_CHAN: resp_r[15:0] <= STAT_CHAN_VAL;
          SID_SER1: resp_r[15:0] <= STAT_SER1_VAL;
          SID_SER2: resp_r[15:0] <= STAT_SER2_VAL;
          SID_REV: resp_r[15:0] <= STAT_REV_VAL;
          SID_PA_CUR: resp_r[15:0] <= pa_current_meas;
          default: resp_r[15:0] <= 16'h0000;
        endcase
      else if (is_read && cmd == CMD_PATH)
        resp_r[15:0] <= {15'h0000, active_path_r};
      else
        resp_r[15:0] <= 16'h0000;
    end
  end

  // transmit shifter: load response while deselected, shift on falling edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_r <= 32'h00000000;
      spi_miso <= 1'b0;
    end else if (cs_n_s) begin
      tx_shift_r <= resp_r;
      spi_miso <= resp_r[31];
    end else if (sclk_fall && bit_cnt_r != 5'h00) begin
      spi_miso <= tx_shift_r[30];
      tx_shift_r <= {tx_shift_r[30:0], 1'b0};
    end
  end

  // active path select command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_path_r <= 1'b0;
    end else if (soft_rst) begin
      active_path_r <= 1'b0;
    end else if (frame_done && !is_read && cmd == CMD_PATH) begin
      active_path_r <= word[0];
    end
  end

  // settings bank writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reference_source_select <= 2'h0;
      reference_output_enable <= 2'h0;
      local_osc_source_select_rx <= 2'h0;
      local_osc_source_select_tx <= 2'h0;
      duplex_path_select <= 1'b0;
      tdd_direction_select <= 1'b0;
      trigger_group_enable <= 2'h0;
      if_filter_rx <= 3'h0;
      if_filter_tx <= 3'h0;
      rx_baseband_filter_select <= 3'h0;
      tx_external_filter_select <= 3'h0;
      antenna_output_lines <= 4'h0;
      cv_gain_rx <= 16'h0000;
      cv_gain_tx <= 16'h0000;
      rx_gain_voltage_one <= 16'h0000;
      rx_gain_voltage_two <= 16'h0000;
      amp_bias_loop_enable <= 1'b0;
      amp_bias_current_target <= 16'h0000;
    end else if (soft_rst) begin
      reference_source_select <= 2'h0;
      reference_output_enable <= 2'h0;
      local_osc_source_select_rx <= 2'h0;
      local_osc_source_select_tx <= 2'h0;
      duplex_path_select <= 1'b0;
      tdd_direction_select <= 1'b0;
      trigger_group_enable <= 2'h0;
      if_filter_rx <= 3'h0;
      if_filter_tx <= 3'h0;
      rx_baseband_filter_select <= 3'h0;
      tx_external_filter_select <= 3'h0;
      antenna_output_lines <= 4'h0;
      cv_gain_rx <= 16'h0000;
      cv_gain_tx <= 16'h0000;
      rx_gain_voltage_one <= 16'h0000;
      rx_gain_voltage_two <= 16'h0000;
      amp_bias_loop_enable <= 1'b0;
      amp_bias_current_target <= 16'h0000;
    end else if (frame_done && !is_read && cmd == CMD_CTRL && id_ok && wr_ok && !ref_clash) begin
      unique case (cid)
        ID_REFERENCE_SOURCE_SELECT: reference_source_select <= val[1:0];
        ID_REF_OUT: reference_output_enable <= val[1:0];
        ID_LOCAL_OSC_SOURCE_SELECT: begin
          if (active_path_r)
            local_osc_source_select_tx <= val[1:0];
          else
            local_osc_source_select_rx <= val[1:0];
        end
        ID_DUPLEX: duplex_path_select <= val[0];
        ID_TDD_DIR: tdd_direction_select <= val[0];
        ID_TRIG: trigger_group_enable <= val[1:0];
        ID_IF_FLT: begin
          if (active_path_r)
            if_filter_tx <= val[2:0];
          else
            if_filter_rx <= val[2:0];
        end
        ID_RXBB_FLT: rx_baseband_filter_select <= val[2:0];
        ID_TXBB_FLT: tx_external_filter_select <= val[2:0];
        ID_ANT: antenna_output_lines <= val[3:0];
        ID_CV_GAIN: begin
          if (active_path_r)
            cv_gain_tx <= val;
          else
            cv_gain_rx <= val;
        end
        ID_RX_GAIN1: rx_gain_voltage_one <= val;
        ID_RX_GAIN2: rx_gain_voltage_two <= val;
        ID_AMP_BIAS_LOOP_ENABLE: amp_bias_loop_enable <= val[0];
        ID_PA_CUR: amp_bias_current_target <= val;
        default: ;
      endcase
    end
  end

  // staged tdd groups: direct when unarmed, on trigger edge when armed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      duplex_switch_position <= 1'b0;
      gain_apply_pulse <= 1'b0;
    end else begin
      if (!trigger_group_enable[TRIG_TDD_BIT] || trig_rise)
        duplex_switch_position <= stage_switch_pos;
      gain_apply_pulse <= trigger_group_enable[TRIG_GAIN_BIT] ? trig_rise
                          : (stage_rx_gain_atten != 2'h0);
    end
  end

  // restart request to the system
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      system_restart_pulse <= 1'b0;
    else
      system_restart_pulse <= soft_rst;
  end
endmodule
`default_nettype wire

//--- hdl/hcib_pkg.sv
package hcib_pkg;
  // command byte layout and command ids
  localparam int OP_BIT = 7;
  localparam logic [6:0] CMD_NULL = 7'h00;
  localparam logic [6:0] CMD_PATH = 7'h03;
  localparam logic [6:0] CMD_CTRL = 7'h04;
  localparam logic [6:0] CMD_STAT = 7'h05;
  localparam int FRAME_BITS = 32;
  localparam int ID_HI = 23;
  localparam int ID_LO = 16;
  // control ids
  localparam logic [7:0] ID_REFERENCE_SOURCE_SELECT = 8'h01;
  localparam logic [7:0] ID_REF_OUT = 8'h02;
  localparam logic [7:0] ID_LOCAL_OSC_SOURCE_SELECT = 8'h03;
  localparam logic [7:0] ID_DUPLEX = 8'h04;
  localparam logic [7:0] ID_TDD_DIR = 8'h05;
  localparam logic [7:0] ID_TRIG = 8'h06;
  localparam logic [7:0] ID_IF_FLT = 8'h07;
  localparam logic [7:0] ID_RXBB_FLT = 8'h08;
  localparam logic [7:0] ID_TXBB_FLT = 8'h09;
  localparam logic [7:0] ID_ANT = 8'h0A;
  localparam logic [7:0] ID_CV_GAIN = 8'h0B;
  localparam logic [7:0] ID_RX_GAIN1 = 8'h0C;
  localparam logic [7:0] ID_RX_GAIN2 = 8'h0D;
  localparam logic [7:0] ID_AMP_BIAS_LOOP_ENABLE = 8'h0E;
  localparam logic [7:0] ID_PA_CUR = 8'h0F;
  localparam logic [7:0] ID_SYS_RST = 8'hFF;
  localparam logic [15:0] RESET_KEY = 16'hA57B;
  // value codes
  localparam logic [15:0] REF_EXTERNAL = 16'h0001;
  localparam logic [15:0] REF_OUT_OFF = 16'h0000;
  localparam logic [15:0] REF_OUT_MAX = 16'h0002;
  localparam logic [15:0] REFERENCE_SOURCE_SELECT_MAX = 16'h0002;
  localparam logic [15:0] LOCAL_OSC_SOURCE_SELECT_MAX = 16'h0002;
  localparam int TRIG_GAIN_BIT = 0;
  localparam int TRIG_TDD_BIT = 1;
  // status ids and their read-only values (values arbitrary)
  localparam logic [7:0] SID_CHAN = 8'h01;
  localparam logic [7:0] SID_SER1 = 8'h02;
  localparam logic [7:0] SID_SER2 = 8'h03;
  localparam logic [7:0] SID_REV = 8'h04;
  localparam logic [7:0] SID_PA_CUR = 8'h05;
  localparam logic [15:0] STAT_CHAN_VAL = 16'h0000;
  localparam logic [15:0] STAT_SER1_VAL = 16'h0123;
  localparam logic [15:0] STAT_SER2_VAL = 16'h4567;
  localparam logic [15:0] STAT_REV_VAL = 16'h0100;
endpackage

//--- hdl/hcib_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for one pin
module hcib_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic pin_out
);
  logic meta_r;
  // first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      meta_r <= pin_in;
      pin_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- verification/hcib_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level checks on the control bank
module hcib_bank_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic ext_trigger,
  input wire logic system_restart_pulse,
  input wire logic [1:0] reference_source_select,
  input wire logic [1:0] reference_output_enable,
  input wire logic [1:0] local_osc_source_select_rx,
  input wire logic [3:0] antenna_output_lines,
  input wire logic [15:0] amp_bias_current_target,
  input wire logic [15:0] cv_gain_rx,
  input wire logic [15:0] cv_gain_tx,
  input wire logic [2:0] if_filter_rx,
  input wire logic active_path_r,
  input wire logic duplex_switch_position,
  input wire logic [1:0] trigger_group_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_restart_single: assert property (system_restart_pulse |=> !system_restart_pulse)
    else $error("restart pulse longer than one cycle");
  a_restart_clears: assert property (system_restart_pulse |-> reference_source_select == 2'h0
    && antenna_output_lines == 4'h0 && cv_gain_rx == 16'h0 && active_path_r == 1'b0)
    else $error("settings not cleared at restart");
  a_ref_exclusive: assert property (!(reference_source_select == 2'h1 && reference_output_enable != 2'h0))
    else $error("external reference with output enabled");
  a_code_range: assert property (reference_source_select != 2'h3 && local_osc_source_select_rx != 2'h3)
    else $error("source code out of range");
  a_ant_in_frame: assert property ($changed(antenna_output_lines) |-> !$past(spi_cs_n, 3))
    else $error("antenna lines changed outside a frame");
  a_cur_in_frame: assert property ($changed(amp_bias_current_target) |-> !$past(spi_cs_n, 3))
    else $error("bias target changed outside a frame");
  a_tx_path_only: assert property ($changed(cv_gain_tx) |-> active_path_r || cv_gain_tx == 16'h0)
    else $error("tx gain changed while rx path active");
  a_rx_path_only: assert property ($changed(if_filter_rx) |-> !active_path_r || if_filter_rx == 3'h0)
    else $error("rx filter changed while tx path active");
  a_switch_trig: assert property ($changed(duplex_switch_position) && trigger_group_enable[1] |->
    ($past(ext_trigger, 2) || $past(ext_trigger, 3) || $past(ext_trigger, 4) || $past(ext_trigger, 5)))
    else $error("armed switch moved without trigger");
endmodule
bind hcib_bank hcib_bank_monitor mon_u (.*);
`default_nettype wire

//--- verification/hcib_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
// serial master: mode 0, 32-bit frames, msb first, 160 ns bit period
module hcib_spi_master (
  input wire logic sys_clk,
  input wire logic spi_miso,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  // idle: clock parked low, device deselected
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end
  // one frame; word is {read, cmd, id, value}, reply is the previous frame's answer
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    @(posedge sys_clk);
    spi_cs_n <= 1'b0;
    spi_mosi <= tx[31];
    for (int i = 31; i >= 0; i--) begin
      repeat (8) @(posedge sys_clk);
      spi_sclk <= 1'b1;
      rx[i] = spi_miso;
      repeat (8) @(posedge sys_clk);
      spi_sclk <= 1'b0;
      spi_mosi <= (i > 0) ? tx[i-1] : ~tx[0]; // data line does not keep the last bit
    end
    repeat (8) @(posedge sys_clk);
    spi_cs_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import hcib_pkg::*;
;
  logic sys_clk, rst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, ext_trigger, stage_switch_pos;
  logic [15:0] pa_current_meas, cv_gain_rx, cv_gain_tx, rx_gain_voltage_one, rx_gain_voltage_two;
  logic [15:0] amp_bias_current_target;
  logic [1:0] stage_rx_gain_atten, reference_source_select, reference_output_enable, local_osc_source_select_rx, local_osc_source_select_tx;
  logic [1:0] trigger_group_enable;
  logic duplex_path_select, tdd_direction_select, amp_bias_loop_enable, active_path_r;
  logic duplex_switch_position, gain_apply_pulse, system_restart_pulse;
  logic [2:0] if_filter_rx, if_filter_tx, rx_baseband_filter_select, tx_external_filter_select;
  logic [3:0] antenna_output_lines;
  logic [31:0] rsp;
  int failures, compares, restarts;
  // quiet time after a gain dac read, scaled down from 10 ms to keep the run short
  localparam int GAIN_READ_GAP = 1000;
  hcib_bank dut_u (.*);
  hcib_spi_master m_u (.*);
  // 100 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // count restart pulses seen on the output
  always @(posedge sys_clk) begin
    if (system_restart_pulse === 1'b1) restarts++;
  end
  // compare and count
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // command frame, then a null frame that fetches its answer
  task automatic op(input logic is_rd, input logic [6:0] cmd, input logic [7:0] id, input logic [15:0] val);
    logic [31:0] dummy;
    m_u.xfer({is_rd, cmd, id, val}, dummy);
    m_u.xfer({1'b0, CMD_NULL, 24'h0}, rsp);
  endtask
  task automatic wr(input logic [7:0] id, input logic [15:0] val, input logic err);
    op(1'b0, CMD_CTRL, id, val);
    check("write answer", rsp, {err, CMD_CTRL, id, 16'h0});
  endtask
  task automatic rdchk(input logic [6:0] cmd, input logic [7:0] id, input logic [15:0] exp);
    op(1'b1, cmd, id, 16'h0);
    check("read answer", rsp, {1'b0, cmd, id, exp});
  endtask
  // all settings at their zero defaults
  task automatic t_zero();
    check("settings a", {reference_source_select, reference_output_enable, local_osc_source_select_rx, local_osc_source_select_tx,
      if_filter_rx, if_filter_tx, rx_baseband_filter_select, tx_external_filter_select, antenna_output_lines,
      duplex_path_select, tdd_direction_select, trigger_group_enable, amp_bias_loop_enable, active_path_r}, 48'h0);
    check("settings b", {cv_gain_rx, cv_gain_tx, amp_bias_current_target}, 48'h0);
    check("settings c", {rx_gain_voltage_one, rx_gain_voltage_two}, 48'h0);
  endtask
  // every filter code, then path steering of the path settings
  task automatic t_filters();
    for (int c = 0; c < 8; c++) begin
      wr(ID_IF_FLT, 16'(c), 1'b0);
      wr(ID_RXBB_FLT, 16'(c), 1'b0);
      wr(ID_TXBB_FLT, 16'(c), 1'b0);
      check("filters", {if_filter_rx, rx_baseband_filter_select,
        tx_external_filter_select}, {3{3'(c)}});
    end
    op(1'b0, CMD_PATH, 8'h00, 16'h0001);
    wr(ID_IF_FLT, 16'h0002, 1'b0);
    wr(ID_CV_GAIN, 16'h0708, 1'b0);
    wr(ID_LOCAL_OSC_SOURCE_SELECT, 16'h0001, 1'b0);
    check("tx path", {if_filter_tx, if_filter_rx, local_osc_source_select_tx, cv_gain_tx, cv_gain_rx},
      {3'h2, 3'h7, 2'h1, 16'h0708, 16'h0});
    rdchk(CMD_CTRL, ID_CV_GAIN, 16'h0708);
    rdchk(CMD_PATH, 8'h00, 16'h0001);
    op(1'b0, CMD_PATH, 8'h00, 16'h0000);
  endtask
  // reference source and output exclusion, code limits
  task automatic t_ref();
    wr(ID_REFERENCE_SOURCE_SELECT, 16'h0002, 1'b0);
    wr(ID_REF_OUT, 16'h0001, 1'b0);
    wr(ID_REFERENCE_SOURCE_SELECT, REF_EXTERNAL, 1'b1);
    check("ref kept", {reference_source_select, reference_output_enable}, {2'h2, 2'h1});
    wr(ID_REF_OUT, REF_OUT_OFF, 1'b0);
    wr(ID_REFERENCE_SOURCE_SELECT, REF_EXTERNAL, 1'b0);
    wr(ID_REF_OUT, REF_OUT_MAX, 1'b1);
    wr(ID_REFERENCE_SOURCE_SELECT, 16'h0003, 1'b1);
    wr(ID_LOCAL_OSC_SOURCE_SELECT, 16'h0002, 1'b0);
    wr(ID_LOCAL_OSC_SOURCE_SELECT, 16'h0003, 1'b1);
    check("ref lo", {reference_source_select, reference_output_enable, local_osc_source_select_rx},
      {2'h1, 2'h0, 2'h2});
  endtask
  // plain settings, write-only reads, status, unknown id
  task automatic t_misc();
    wr(ID_DUPLEX, 16'h0001, 1'b0);
    wr(ID_TDD_DIR, 16'h0001, 1'b0);
    wr(ID_ANT, 16'h0005, 1'b0);
    wr(ID_RX_GAIN1, 16'h05DC, 1'b0);
    wr(ID_RX_GAIN2, 16'h0123, 1'b0);
    wr(ID_AMP_BIAS_LOOP_ENABLE, 16'h0001, 1'b0);
    wr(ID_PA_CUR, 16'h02BC, 1'b0);
    check("misc", {duplex_path_select, tdd_direction_select,
      antenna_output_lines, amp_bias_loop_enable, amp_bias_current_target}, {1'b1, 1'b1, 4'h5, 1'b1, 16'h02BC});
    check("rx gains", {rx_gain_voltage_one, rx_gain_voltage_two}, {16'h05DC, 16'h0123});
    rdchk(CMD_CTRL, ID_RX_GAIN2, 16'h0123);
    repeat (GAIN_READ_GAP) @(posedge sys_clk);
    rdchk(CMD_CTRL, ID_PA_CUR, 16'h0000);
    rdchk(CMD_STAT, SID_PA_CUR, 16'h02BC);
    wr(8'h10, 16'h000A, 1'b1);
    wr(ID_ANT, 16'h000A, 1'b0);
    check("antenna", antenna_output_lines, 4'hA);
    op(1'b0, 7'h10, ID_ANT, 16'h0003);
    check("bad cmd", {rsp, antenna_output_lines}, {1'b1, 7'h10, ID_ANT, 16'h0000, 4'hA});
  endtask
  // count apply pulses over a short span
  task automatic pulses(output int n);
    n = 0;
    repeat (12) begin
      @(posedge sys_clk);
      #1;
      if (gain_apply_pulse === 1'b1) n++;
    end
    @(posedge sys_clk);
  endtask
  // armed groups wait for the trigger
  task automatic t_trig();
    int n;
    wr(ID_TRIG, 16'h0002, 1'b0);
    stage_switch_pos <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check("switch armed", duplex_switch_position, 1'b0);
    ext_trigger <= 1'b1;
    repeat (10) @(posedge sys_clk);
    check("switch fired", duplex_switch_position, 1'b1);
    ext_trigger <= 1'b0;
    stage_rx_gain_atten <= 2'h1;
    pulses(n);
    check("gain direct", n, 12);
    wr(ID_TRIG, 16'h0001, 1'b0);
    stage_rx_gain_atten <= 2'h1;
    pulses(n);
    check("gain armed", n, 0);
    ext_trigger <= 1'b1;
    pulses(n);
    check("gain fired", n, 1);
    ext_trigger <= 1'b0;
    stage_rx_gain_atten <= 2'h0;
  endtask
  // wrong key refused, right key restores defaults
  task automatic t_key();
    wr(ID_SYS_RST, 16'hA57A, 1'b1);
    check("key kept", antenna_output_lines, 4'hA);
    wr(ID_SYS_RST, RESET_KEY, 1'b0);
    check("restart pulse", restarts, 1);
    t_zero();
  endtask
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, about one and a half times the expected run
  initial begin
    repeat (95000) @(posedge sys_clk);
    failures++;
    final_report();
  end
  initial begin
    failures = 0;
    compares = 0;
    restarts = 0;
    rst_n = 1'b0;
    ext_trigger = 1'b0;
    stage_switch_pos = 1'b0;
    stage_rx_gain_atten = 2'h0;
    pa_current_meas = 16'h02BC;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    t_zero();
    t_filters();
    t_ref();
    t_misc();
    t_trig();
    t_key();
    final_report();
  end
endmodule
`default_nettype wire
